//--- inc/adc_cfg_consts.vh
// Constants for the converter clock, repeat and gain access block
// Notes on behaviour
// - The conversion clock is the source clock divided by the 5-bit divisor in bits 7:3 plus one.
// - With burst mode off the divider runs from the system clock itself.
// - With burst mode on the divider runs from a fixed source of at most 30 MHz.
// - Repeat codes 00, 01, 10, 11 select 1, 4, 8, 16 conversions; interrupts come after the last.
// - Outside burst mode each conversion needs its own start; in burst mode one start runs all.
// - Every conversion result of a sequence is added into the result high and low bytes.
// - Bit 0 of the configuration register enables the gain programming path.
// - With gain access on, a high-byte write picks a gain address and a low-byte write loads it.
// - The gain registers are write-only and never show on reads.
`ifndef ADC_CFG_CONSTS_VH
`define ADC_CFG_CONSTS_VH

// Register addresses
`define CFG_ADDR 8'hBC
`define RES_HIGH_ADDR 8'hC1
`define RES_LOW_ADDR 8'hC2
`define CFG_RESET 8'hF8

// Configuration fields
`define CFG_DIV_MSB 7
`define CFG_DIV_LSB 3
`define CFG_RPT_MSB 2
`define CFG_RPT_LSB 1
`define CFG_GAIN_BIT 0

// Gain register addresses written through the result high byte
`define GAIN_UPPER_ADDR 8'h04
`define GAIN_LOWER_ADDR 8'h07
`define GAIN_ADD_ADDR 8'h08

// Repeat counts
`define RPT_CODE_1 2'h0
`define RPT_CODE_4 2'h1
`define RPT_CODE_8 2'h2
`define RPT_COUNT_1 5'h01
`define RPT_COUNT_4 5'h04
`define RPT_COUNT_8 5'h08
`define RPT_COUNT_16 5'h10

// Clock rates and burst source divide, rounded up so the source stays at or below its limit
`define SYS_CLK_MHZ 250
`define BURST_SRC_MAX_MHZ 30
`define BURST_DIV ((`SYS_CLK_MHZ + `BURST_SRC_MAX_MHZ - 1) / `BURST_SRC_MAX_MHZ)

`endif

//--- rtl/adc_clock_repeat_config.v
// Converter clock, repeat-accumulate sequencer and gain access control
`timescale 1ns/100ps
`include "adc_cfg_consts.vh"
module adc_clock_repeat_config #(
  parameter RES_W = 12,
  parameter ACC_W = 16,
  parameter BURST_DIV = `BURST_DIV
) (
  input wire CLK, // System clock, 250 MHz
  input wire RST, // Synchronous reset, high
  input wire [7:0] SFR_ADDR, // Register address
  input wire [7:0] SFR_WDATA, // Write data
  input wire SFR_WR, // Write strobe, one cycle
  input wire SFR_RD, // Read strobe, one cycle
  output reg [7:0] SFR_RDATA, // Read data, one cycle after the strobe
  input wire BURST_MODE_ENABLE, // Burst mode level
  input wire CONVERT_START, // Convert start pulse
  input wire CONV_DONE, // Converter finished one conversion
  input wire [RES_W-1:0] CONV_RESULT, // Result with CONV_DONE
  input wire WINDOW_MATCH, // Window comparator verdict on RESULT
  output reg CONV_REQUEST, // Start one conversion, pulse
  output wire CONV_CLK_TICK, // Conversion clock tick
  output wire CONV_CLK, // Conversion clock level
  output reg [ACC_W-1:0] RESULT, // Accumulated result
  output reg CONVERSION_DONE_IRQ, // Sequence complete pulse
  output reg WINDOW_COMPARE_IRQ, // Window hit at sequence end pulse
  output reg SEQ_BUSY, // Sequence in progress
  output reg [7:0] GAIN_UPPER_BYTE, // Gain upper byte
  output reg [3:0] GAIN_LOWER_NIBBLE, // Gain lower nibble
  output reg GAIN_ADD_CONTROL // Gain add control bit
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [7:0] cfg_reg;
  reg [7:0] gain_addr_reg;
  reg [3:0] burst_cnt_reg;
  reg burst_tick_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [4:0] target_reg;
  reg [4:0] done_cnt_reg;
  reg [4:0] target_sel;
  reg [ACC_W-1:0] acc_sum;
  reg [7:0] rdata_next;
  wire src_tick;
  wire wr_cfg;
  wire wr_high;
  wire wr_low;
  wire gain_access_enable;
  wire [4:0] sar_clock_divisor;
  wire [1:0] repeat_count_select;
  wire last_conv;

  assign sar_clock_divisor = cfg_reg[`CFG_DIV_MSB:`CFG_DIV_LSB];
  assign repeat_count_select = cfg_reg[`CFG_RPT_MSB:`CFG_RPT_LSB];
  assign gain_access_enable = cfg_reg[`CFG_GAIN_BIT];
  assign wr_cfg = SFR_WR && (SFR_ADDR == `CFG_ADDR);
  assign wr_high = SFR_WR && (SFR_ADDR == `RES_HIGH_ADDR);
  assign wr_low = SFR_WR && (SFR_ADDR == `RES_LOW_ADDR);

  // Configuration register write
  always @(posedge CLK) begin
    if (RST) begin
      cfg_reg <= `CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= SFR_WDATA;
    end
  end

  // Fixed burst source from the system clock; it ignores whatever core clock is chosen
  always @(posedge CLK) begin
    if (RST) begin
      burst_cnt_reg <= 4'h0;
      burst_tick_reg <= 1'b0;
    end else if (burst_cnt_reg == BURST_DIV[3:0] - 4'h1) begin
      burst_cnt_reg <= 4'h0;
      burst_tick_reg <= 1'b1;
    end else begin
      burst_cnt_reg <= burst_cnt_reg + 4'h1;
      burst_tick_reg <= 1'b0;
    end
  end

  // Source select: system clock runs every cycle, burst source only on its ticks
  assign src_tick = BURST_MODE_ENABLE ? burst_tick_reg : 1'b1;

  sar_clock_divider #(
    .DIV_W(5)
  ) u_div (
    .clk(CLK),
    .rst(RST),
    .src_tick(src_tick),
    .divisor(sar_clock_divisor),
    .conv_tick_reg(CONV_CLK_TICK),
    .conv_level_reg(CONV_CLK)
  );

  // Repeat code to number of conversions
  always @* begin
    case (repeat_count_select)
      `RPT_CODE_1: target_sel = `RPT_COUNT_1;
      `RPT_CODE_4: target_sel = `RPT_COUNT_4;
      `RPT_CODE_8: target_sel = `RPT_COUNT_8;
      default: target_sel = `RPT_COUNT_16;
    endcase
  end

  // Running sum of this conversion onto the accumulator
  always @* begin
    acc_sum = RESULT + {{(ACC_W-RES_W){1'b0}}, CONV_RESULT};
  end

  assign last_conv = (done_cnt_reg + 5'h01) == target_reg;

  // Sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (CONVERT_START) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (CONV_DONE) begin
          if (last_conv) begin
            state_next = ST_IDLE;
          end else if (BURST_MODE_ENABLE) begin
            state_next = ST_CONV;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (CONVERT_START) begin
          state_next = ST_CONV;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers, accumulator and interrupt pulses
  always @(posedge CLK) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      target_reg <= `RPT_COUNT_1;
      done_cnt_reg <= 5'h00;
      RESULT <= {ACC_W{1'b0}};
      CONV_REQUEST <= 1'b0;
      CONVERSION_DONE_IRQ <= 1'b0;
      WINDOW_COMPARE_IRQ <= 1'b0;
      SEQ_BUSY <= 1'b0;
    end else begin
      state_reg <= state_next;
      CONV_REQUEST <= 1'b0;
      CONVERSION_DONE_IRQ <= 1'b0;
      WINDOW_COMPARE_IRQ <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (CONVERT_START) begin
            // Count is latched so a mid-sequence change cannot strand the sequencer
            target_reg <= target_sel;
            done_cnt_reg <= 5'h00;
            RESULT <= {ACC_W{1'b0}};
            CONV_REQUEST <= 1'b1;
            SEQ_BUSY <= 1'b1;
          end
        end
        ST_CONV: begin
          if (CONV_DONE) begin
            RESULT <= acc_sum;
            done_cnt_reg <= done_cnt_reg + 5'h01;
            if (last_conv) begin
              CONVERSION_DONE_IRQ <= 1'b1;
              SEQ_BUSY <= 1'b0;
            end else if (BURST_MODE_ENABLE) begin
              CONV_REQUEST <= 1'b1;
            end
          end
        end
        ST_WAIT: begin
          if (CONVERT_START) begin
            CONV_REQUEST <= 1'b1;
          end
        end
        default: begin
          SEQ_BUSY <= 1'b0;
        end
      endcase
      // Window verdict is taken on the finished total, one cycle after the done pulse
      if (CONVERSION_DONE_IRQ && WINDOW_MATCH) begin
        WINDOW_COMPARE_IRQ <= 1'b1;
      end
    end
  end

  // Gain access path: high byte picks the target, low byte loads it
  always @(posedge CLK) begin
    if (RST) begin
      gain_addr_reg <= 8'h00;
      GAIN_UPPER_BYTE <= 8'h00;
      GAIN_LOWER_NIBBLE <= 4'h0;
      GAIN_ADD_CONTROL <= 1'b0;
    end else if (gain_access_enable) begin
      if (wr_high) begin
        gain_addr_reg <= SFR_WDATA;
      end
      if (wr_low) begin
        case (gain_addr_reg)
          `GAIN_UPPER_ADDR: GAIN_UPPER_BYTE <= SFR_WDATA;
          `GAIN_LOWER_ADDR: GAIN_LOWER_NIBBLE <= SFR_WDATA[7:4];
          `GAIN_ADD_ADDR: GAIN_ADD_CONTROL <= SFR_WDATA[0];
          default: GAIN_ADD_CONTROL <= GAIN_ADD_CONTROL;
        endcase
      end
    end
  end

  // Read mux; gain values are never on it, only the configuration and result bytes
  always @* begin
    case (SFR_ADDR)
      `CFG_ADDR: rdata_next = cfg_reg;
      `RES_HIGH_ADDR: rdata_next = RESULT[15:8];
      `RES_LOW_ADDR: rdata_next = RESULT[7:0];
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data is held until the next read strobe
  always @(posedge CLK) begin
    if (RST) begin
      SFR_RDATA <= 8'h00;
    end else if (SFR_RD) begin
      SFR_RDATA <= rdata_next;
    end
  end

endmodule

//--- rtl/sar_clock_divider.v
// Conversion clock divider counting source ticks
`timescale 1ns/100ps
module sar_clock_divider #(
  parameter DIV_W = 5
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, high
  input wire src_tick, // One pulse per source clock period
  input wire [DIV_W-1:0] divisor, // Divide by divisor plus one
  output reg conv_tick_reg, // One pulse per conversion clock period
  output reg conv_level_reg // Square conversion clock level
);

  reg [DIV_W-1:0] count_reg;

  // Counter wraps at the divisor, so the period is divisor plus one source ticks
  always @(posedge clk) begin
    if (rst) begin
      count_reg <= {DIV_W{1'b0}};
      conv_tick_reg <= 1'b0;
      conv_level_reg <= 1'b0;
    end else begin
      conv_tick_reg <= 1'b0;
      if (src_tick) begin
        if (count_reg >= divisor) begin
          count_reg <= {DIV_W{1'b0}};
          conv_tick_reg <= 1'b1;
          conv_level_reg <= ~conv_level_reg;
        end else begin
          count_reg <= count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule

//--- tb/adc_cfg_monitor.sv
// Port assertions for the converter clock, repeat and gain block
`timescale 1ns/100ps
module adc_cfg_monitor #(
  parameter ACC_W = 16
) (
  input wire CLK, // System clock
  input wire RST, // Reset
  input wire [7:0] SFR_ADDR, // Address
  input wire SFR_WR, // Write strobe
  input wire SFR_RD, // Read strobe
  input wire [7:0] SFR_RDATA, // Read data
  input wire BURST_MODE_ENABLE, // Burst level
  input wire CONVERT_START, // Start pulse
  input wire CONV_DONE, // Conversion end
  input wire WINDOW_MATCH, // Window verdict
  input wire CONV_REQUEST, // Request pulse
  input wire [ACC_W-1:0] RESULT, // Accumulator
  input wire CONVERSION_DONE_IRQ, // Sequence end
  input wire WINDOW_COMPARE_IRQ, // Window hit
  input wire SEQ_BUSY, // Busy
  input wire [7:0] GAIN_UPPER_BYTE // Gain byte
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Decode and result byte views used below
  wire mapped = SFR_ADDR == 8'hBC || SFR_ADDR == 8'hC1 || SFR_ADDR == 8'hC2;
  wire [7:0] res_hi = RESULT[15:8];
  wire [7:0] res_lo = RESULT[7:0];
  a_unmapped_zero: assert property ($past(SFR_RD && !mapped) |-> SFR_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_high_read: assert property ($past(SFR_RD && SFR_ADDR == 8'hC1) |-> SFR_RDATA == $past(res_hi))
    else $error("high byte read wrong");
  a_low_read: assert property ($past(SFR_RD && SFR_ADDR == 8'hC2) |-> SFR_RDATA == $past(res_lo))
    else $error("low byte read wrong");
  a_start_request: assert property (!SEQ_BUSY && CONVERT_START |=> CONV_REQUEST && SEQ_BUSY)
    else $error("start gave no request");
  a_start_needed: assert property (CONV_REQUEST && !BURST_MODE_ENABLE &&
    !$past(BURST_MODE_ENABLE) |-> $past(CONVERT_START))
    else $error("request without start");
  a_clear_on_start: assert property (CONV_REQUEST && !$past(SEQ_BUSY) |-> RESULT == 0)
    else $error("accumulator not cleared");
  a_done_ends_busy: assert property (CONVERSION_DONE_IRQ |->
    !SEQ_BUSY && $past(SEQ_BUSY) && $past(CONV_DONE))
    else $error("done irq out of place");
  a_window_order: assert property (WINDOW_COMPARE_IRQ |-> $past(CONVERSION_DONE_IRQ))
    else $error("window irq early");
  a_window_fires: assert property (CONVERSION_DONE_IRQ && WINDOW_MATCH |=> WINDOW_COMPARE_IRQ)
    else $error("window irq missing");
  a_gain_source: assert property ($changed(GAIN_UPPER_BYTE) |-> $past(SFR_WR && SFR_ADDR == 8'hC2))
    else $error("gain byte changed alone");
  // Main scenarios reached
  c_done: cover property (CONVERSION_DONE_IRQ);
  c_window: cover property (WINDOW_COMPARE_IRQ);
  c_gain: cover property ($changed(GAIN_UPPER_BYTE));
endmodule

bind adc_clock_repeat_config adc_cfg_monitor #(.ACC_W(ACC_W)) i_adc_cfg_monitor (
  .CLK(CLK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
  .SFR_RDATA(SFR_RDATA), .BURST_MODE_ENABLE(BURST_MODE_ENABLE),
  .CONVERT_START(CONVERT_START), .CONV_DONE(CONV_DONE), .WINDOW_MATCH(WINDOW_MATCH),
  .CONV_REQUEST(CONV_REQUEST), .RESULT(RESULT), .CONVERSION_DONE_IRQ(CONVERSION_DONE_IRQ),
  .WINDOW_COMPARE_IRQ(WINDOW_COMPARE_IRQ), .SEQ_BUSY(SEQ_BUSY),
  .GAIN_UPPER_BYTE(GAIN_UPPER_BYTE));

//--- tb/testbench.sv
// Self-checking bench for the converter clock, repeat and gain block
`timescale 1ns/100ps
module testbench;
  localparam BD = 9;
  reg CLK = 0;
  reg RST = 1;
  reg [7:0] SFR_ADDR = 0, SFR_WDATA = 0;
  reg SFR_WR = 0, SFR_RD = 0, BURST = 0, START = 0, DONE = 0, MATCH = 0;
  reg [11:0] CRES = 0;
  wire [7:0] SFR_RDATA, GUB;
  wire [3:0] GLN;
  wire REQ, TICK, CCLK, IRQ, WIRQ, BUSY, GAC;
  wire [15:0] RESULT;
  integer mismatches = 0, checks = 0, i, j, k, n, s, seed;
  reg [15:0] expq[$];
  reg [15:0] last;
  reg cl;
  reg [11:0] r[0:15];
  always #2 CLK = ~CLK;
  adc_clock_repeat_config #(.BURST_DIV(BD)) i_adc_clock_repeat_config (.CLK(CLK), .RST(RST),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA), .BURST_MODE_ENABLE(BURST), .CONVERT_START(START),
    .CONV_DONE(DONE), .CONV_RESULT(CRES), .WINDOW_MATCH(MATCH), .CONV_REQUEST(REQ),
    .CONV_CLK_TICK(TICK), .CONV_CLK(CCLK), .RESULT(RESULT), .CONVERSION_DONE_IRQ(IRQ),
    .WINDOW_COMPARE_IRQ(WIRQ), .SEQ_BUSY(BUSY), .GAIN_UPPER_BYTE(GUB),
    .GAIN_LOWER_NIBBLE(GLN), .GAIN_ADD_CONTROL(GAC));
  task check(input [15:0] e, input [15:0] g);
    begin
      checks = checks + 1;
      if (e !== g) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: expected %h got %h", $time, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      if (mismatches == 0 && checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Bus cycles, one strobe cycle then a quiet cycle
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge CLK);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1;
      @(negedge CLK);
      SFR_WR = 0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      expq.push_back(e);
      @(negedge CLK);
      SFR_ADDR = a;
      SFR_RD = 1;
      @(negedge CLK);
      SFR_RD = 0;
    end
  endtask
  // Scoreboard: read data and sequence totals against the oldest note
  always @(posedge CLK) begin
    #1;
    if (SFR_RD === 1'b1 || IRQ === 1'b1) begin
      if (expq.size() == 0)
        check(16'h0001, 16'h0000);
      else
        check(expq.pop_front(), SFR_RD === 1'b1 ? {8'h00, SFR_RDATA} : RESULT);
    end
  end
  task wait_req;
    begin
      n = 0;
      while (REQ !== 1'b1 && n < 40) begin
        @(negedge CLK);
        n = n + 1;
      end
      if (n == 40)
        check(16'h0001, 16'h0000);
    end
  endtask
  // One repeat sequence with random results; the total is noted before it starts
  task seq(input [1:0] code, input b);
    begin
      s = 0;
      k = code ? 1 << (code + 1) : 1;
      for (j = 0; j < k; j = j + 1) begin
        r[j] = $urandom;
        s = s + r[j];
      end
      last = s;
      wr(8'hBC, {5'h1F, code, 1'b0});
      BURST = b;
      MATCH = $urandom;
      expq.push_back(last);
      for (j = 0; j < k; j = j + 1) begin
        if (j == 0 || !b) begin
          START = 1;
          @(negedge CLK);
          START = 0;
        end
        wait_req;
        if (j == 0)
          check(16'h0001, {15'h0, BUSY});
        // Let one to four edges pass after the request so DONE is never lowered and raised at once
        repeat (1 + $urandom % 4) @(negedge CLK);
        DONE = 1;
        CRES = r[j];
        @(negedge CLK);
        DONE = 0;
      end
      // Window pulse stands the cycle after the done pulse; busy has fallen by then
      @(negedge CLK);
      check({14'h0, MATCH, 1'b0}, {14'h0, WIRQ, BUSY});
      repeat (3) @(negedge CLK);
    end
  endtask
  // Tick spacing; the first intervals absorb a divisor change mid-count
  task tick(input [4:0] d, input b, input [15:0] e);
    begin
      wr(8'hBC, {d, 3'h0});
      BURST = b;
      repeat (3) begin
        cl = CCLK;
        n = 0;
        @(posedge CLK);
        #1;
        while (TICK !== 1'b1 && n < 600) begin
          @(posedge CLK);
          #1;
          n = n + 1;
        end
      end
      check(e, n + 1);
      check({15'h0, ~cl}, {15'h0, CCLK});
    end
  endtask
  initial begin
    seed = $urandom(35669);
    repeat (10) @(posedge CLK);
    @(negedge CLK);
    RST = 0;
    rd(8'hBC, 16'h00F8);
    rd(8'h55, 16'h0000);
    tick(5'h00, 0, 1);
    tick(5'h05, 0, 6);
    tick(5'h1F, 0, 32);
    tick(5'h00, 1, BD);
    tick(5'h1F, 1, BD * 32);
    for (i = 0; i < 8; i = i + 1) begin
      seq(i[1:0], i[2]);
      rd(8'hC1, last[15:8]);
      rd(8'hC2, last[7:0]);
    end
    wr(8'hBC, 8'h01);
    wr(8'hC1, 8'h04);
    wr(8'hC2, 8'h6C);
    wr(8'hC1, 8'h07);
    wr(8'hC2, 8'hA0);
    wr(8'hC1, 8'h08);
    wr(8'hC2, 8'h01);
    wr(8'hC1, 8'h05);
    wr(8'hC2, 8'hFF);
    rd(8'hC2, last[7:0]);
    wr(8'hBC, 8'h00);
    wr(8'hC1, 8'h04);
    wr(8'hC2, 8'h33);
    check(16'h1A6C, {3'h0, GAC, GLN, GUB});
    rd(8'hBC, 16'h0000);
    repeat (4) @(negedge CLK);
    stop_test;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #40000;
    mismatches = mismatches + 1;
    stop_test;
  end
endmodule
